// File: rtl/bfs_pkg.sv
package bfs_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STAT = 12'h004;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
   // control fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_SS_DONE_BIT = 1;
   localparam int CTRL_PHASE_ADD_BIT = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
   // event bit positions, shared by status, sticky and mask
   localparam int EV_INPUT_OV = 0;
   localparam int EV_OUTPUT_OV = 1;
   localparam int EV_UNDERVOLT = 2;
   localparam int EV_FB_OV = 3;
   localparam int EV_CHAN_OC = 4;
   localparam int EV_TOTAL_OC = 5;
   localparam int EV_OVERTEMP = 6;
   localparam int EV_LATCHED = 7;
   localparam int EV_WIDTH = 8;
   // timing
   localparam int CLK_MHZ = 250;
   localparam int TOTAL_OC_US = 100;
   localparam int BLANK_US = 200;
   localparam int TOTAL_OC_CYCLES = TOTAL_OC_US * CLK_MHZ;
   localparam int BLANK_CYCLES = BLANK_US * CLK_MHZ;
   localparam int CNT_W = 16;
   localparam int CHANNELS = 4;
   localparam int SYNC_STAGES = 2;
endpackage : bfs_pkg

// File: rtl/bfs_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a bus of comparator levels
module bfs_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         syncOut <= '0;
      end else begin
         meta_ff <= asyncIn;
         syncOut <= meta_ff;
      end
   end
endmodule : bfs_sync

// File: rtl/bfs_supervisor.sv
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module bfs_supervisor #(
   parameter int TOTAL_OC_CYCLES = bfs_pkg::TOTAL_OC_CYCLES,
   parameter int BLANK_CYCLES = bfs_pkg::BLANK_CYCLES,
   parameter int CHANNELS = bfs_pkg::CHANNELS
) (
   input wire logic clk,
   input wire logic rst_n,
   // comparator outputs; each hysteresis band lives in the analog comparator
   input wire logic inputSenseHigh,
   input wire logic outputSenseHigh,
   input wire logic feedbackUnder,
   input wire logic feedbackOver,
   input wire logic [CHANNELS-1:0] channelCurrentAmpTrip,
   input wire logic totalCurrentMonitorHigh,
   input wire logic softStartClamped,
   input wire logic overTemp,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // open-drain flags: output enable high pulls the pin low
   output logic powerGoodOut,
   output logic powerGoodOe,
   output logic inputOvervoltageFlagOe,
   output logic outputOvervoltageFlagOe,
   output logic converterRun,
   output logic channelPeakLimit,
   output logic irq
);
   localparam int NSYNC = CHANNELS + 8;
   localparam logic [bfs_pkg::CNT_W-1:0] TOC_LAST =
      bfs_pkg::CNT_W'(TOTAL_OC_CYCLES - 1);
   localparam logic [bfs_pkg::CNT_W-1:0] BLK_LAST =
      bfs_pkg::CNT_W'(BLANK_CYCLES - 1);

   typedef enum logic [3:0] {
      BFS_OFF = 4'h1,
      BFS_SOFT = 4'h2,
      BFS_RUN = 4'h4,
      BFS_LATCH = 4'h8
   } bfs_state_t;

   logic [NSYNC-1:0] syncIn;
   logic [NSYNC-1:0] syncLvl;
   logic inOv, outOv, fbUnder, fbOver, totHigh, ssClamp, hot;
   logic [CHANNELS-1:0] chTrip;

   // every threshold crossing enters through the synchroniser
   assign syncIn = {channelCurrentAmpTrip, overTemp, softStartClamped,
                    totalCurrentMonitorHigh, feedbackOver, feedbackUnder,
                    outputSenseHigh, inputSenseHigh, 1'b0};

   bfs_sync #(.WIDTH(NSYNC)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(syncIn),
      .syncOut(syncLvl)
   );

   assign inOv = syncLvl[1];
   assign outOv = syncLvl[2];
   assign fbUnder = syncLvl[3];
   assign fbOver = syncLvl[4];
   assign totHigh = syncLvl[5];
   assign ssClamp = syncLvl[6];
   assign hot = syncLvl[7];
   assign chTrip = syncLvl[NSYNC-1:8];

   logic [31:0] ctrl_ff;
   logic [bfs_pkg::EV_WIDTH-1:0] irqStat_ff;
   logic [bfs_pkg::EV_WIDTH-1:0] irqMask_ff;
   bfs_state_t state_ff, nxt_state;
   logic [bfs_pkg::CNT_W-1:0] totCnt_ff;
   logic [bfs_pkg::CNT_W-1:0] blankCnt_ff;
   logic blanking_ff;
   logic phaseAddDly_ff;
   logic totTrip_ff;
   logic enable, ssDone, phaseAdd;

   assign enable = ctrl_ff[bfs_pkg::CTRL_ENABLE_BIT];
   assign ssDone = ctrl_ff[bfs_pkg::CTRL_SS_DONE_BIT];
   assign phaseAdd = ctrl_ff[bfs_pkg::CTRL_PHASE_ADD_BIT];

   function automatic logic isAccess(input logic [11:0] off);
      isAccess = psel && penable && paddr == off;
   endfunction : isAccess

   logic wrEn;
   assign wrEn = psel && penable && pwrite;

   // control register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= bfs_pkg::CTRL_RESET;
      end else if (wrEn && isAccess(bfs_pkg::OFF_CTRL)) begin
         ctrl_ff <= {29'h0000_0000, pwdata[2:0]};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqMask_ff <= bfs_pkg::IRQ_MASK_RESET;
      end else if (wrEn && isAccess(bfs_pkg::OFF_IRQ_MASK)) begin
         irqMask_ff <= pwdata[bfs_pkg::EV_WIDTH-1:0];
      end
   end

   // blanking window restarts on each new phase-adding request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phaseAddDly_ff <= 1'b0;
         blanking_ff <= 1'b0;
         blankCnt_ff <= '0;
      end else begin
         phaseAddDly_ff <= phaseAdd;
         if (!phaseAdd) begin
            blanking_ff <= 1'b0;
            blankCnt_ff <= '0;
         end else if (!phaseAddDly_ff) begin
            blanking_ff <= 1'b1;
            blankCnt_ff <= '0;
         end else if (blanking_ff) begin
            if (blankCnt_ff == BLK_LAST) begin
               blanking_ff <= 1'b0;
            end else begin
               blankCnt_ff <= blankCnt_ff + 1'b1;
            end
         end
      end
   end

   // total current must stay high for the full window, no gaps allowed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         totCnt_ff <= '0;
         totTrip_ff <= 1'b0;
      end else if (!totHigh || !ssClamp || state_ff != BFS_RUN) begin
         totCnt_ff <= '0;
         totTrip_ff <= 1'b0;
      end else if (totCnt_ff == TOC_LAST) begin
         totTrip_ff <= 1'b1;
      end else begin
         totCnt_ff <= totCnt_ff + 1'b1;
      end
   end

   logic chanOcFault, shutdownReq;
   // soft-start keeps running at peak limit rather than latching
   assign chanOcFault = (|chTrip) && !blanking_ff && state_ff == BFS_RUN;
   assign shutdownReq = chanOcFault || totTrip_ff || outOv;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         BFS_OFF: begin
            if (enable && !hot && !outOv) begin
               nxt_state = BFS_SOFT;
            end
         end
         BFS_SOFT: begin
            if (!enable || hot) begin
               nxt_state = BFS_OFF;
            end else if (outOv) begin
               nxt_state = BFS_LATCH;
            end else if (ssDone && ssClamp) begin
               nxt_state = BFS_RUN;
            end
         end
         BFS_RUN: begin
            if (!enable || hot) begin
               nxt_state = BFS_OFF;
            end else if (shutdownReq) begin
               nxt_state = BFS_LATCH;
            end
         end
         BFS_LATCH: begin
            // only clearing enable leaves the latch
            if (!enable) begin
               nxt_state = BFS_OFF;
            end
         end
         default: nxt_state = BFS_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= BFS_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   logic pgFault, pgGood;
   // feedback overvoltage only counts after soft-start
   assign pgFault = fbUnder || (fbOver && state_ff == BFS_RUN) ||
                    chanOcFault || totTrip_ff || hot;
   assign pgGood = state_ff == BFS_RUN && !pgFault;

   logic [bfs_pkg::EV_WIDTH-1:0] evLvl;
   always_comb begin
      evLvl = '0;
      evLvl[bfs_pkg::EV_INPUT_OV] = inOv;
      evLvl[bfs_pkg::EV_OUTPUT_OV] = outOv;
      evLvl[bfs_pkg::EV_UNDERVOLT] = fbUnder;
      evLvl[bfs_pkg::EV_FB_OV] = fbOver && state_ff == BFS_RUN;
      evLvl[bfs_pkg::EV_CHAN_OC] = chanOcFault;
      evLvl[bfs_pkg::EV_TOTAL_OC] = totTrip_ff;
      evLvl[bfs_pkg::EV_OVERTEMP] = hot;
      evLvl[bfs_pkg::EV_LATCHED] = state_ff == BFS_LATCH;
   end

   // set wins over the write-one clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat_ff <= '0;
      end else if (wrEn && isAccess(bfs_pkg::OFF_IRQ_STAT)) begin
         irqStat_ff <= (irqStat_ff & ~pwdata[bfs_pkg::EV_WIDTH-1:0]) | evLvl;
      end else begin
         irqStat_ff <= irqStat_ff | evLvl;
      end
   end

   // power good pin pulled low out of reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         powerGoodOut <= 1'b0;
      end else begin
         powerGoodOut <= pgGood;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         powerGoodOe <= 1'b1;
      end else begin
         powerGoodOe <= !pgGood;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inputOvervoltageFlagOe <= 1'b0;
      end else begin
         inputOvervoltageFlagOe <= inOv;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         outputOvervoltageFlagOe <= 1'b0;
      end else begin
         outputOvervoltageFlagOe <= outOv;
      end
   end

   // taken from the next state so a stop costs no extra cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         converterRun <= 1'b0;
      end else begin
         // feedback overvoltage leaves switching alone
         converterRun <= nxt_state == BFS_SOFT || nxt_state == BFS_RUN;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         channelPeakLimit <= 1'b0;
      end else begin
         channelPeakLimit <= state_ff == BFS_SOFT;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat_ff & irqMask_ff);
      end
   end

   // apb read path: one wait-free access, unmapped reads zero with error
   logic mapped;
   assign mapped = paddr == bfs_pkg::OFF_CTRL || paddr == bfs_pkg::OFF_STAT ||
                   paddr == bfs_pkg::OFF_IRQ_STAT ||
                   paddr == bfs_pkg::OFF_IRQ_MASK;

   // ready answers the setup cycle, so every access has no wait state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && !penable && !mapped;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               bfs_pkg::OFF_CTRL: prdata <= ctrl_ff;
               bfs_pkg::OFF_STAT: prdata <= {20'h00000, state_ff, evLvl};
               bfs_pkg::OFF_IRQ_STAT: prdata <= {24'h000000, irqStat_ff};
               bfs_pkg::OFF_IRQ_MASK: prdata <= {24'h000000, irqMask_ff};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule : bfs_supervisor

// File: verification/bfs_supervisor_properties.sv
`timescale 1ns/1ps
module bfs_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inputSenseHigh,
   input wire logic outputSenseHigh,
   input wire logic feedbackUnder,
   input wire logic feedbackOver,
   input wire logic overTemp,
   input wire logic psel,
   input wire logic powerGoodOut,
   input wire logic powerGoodOe,
   input wire logic inputOvervoltageFlagOe,
   input wire logic outputOvervoltageFlagOe,
   input wire logic converterRun,
   input wire logic channelPeakLimit
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // four cycles cover the two synchroniser flops plus the output register
   a_pg_pin_inv: assert property (powerGoodOe == !powerGoodOut)
      else $error("power good pin not inverse of output");
   a_soft_pg_low: assert property (channelPeakLimit |-> !powerGoodOut)
      else $error("power good high in soft-start");
   a_uv_pg_low: assert property (feedbackUnder [*4] |-> !powerGoodOut)
      else $error("power good high under undervoltage");
   a_ov_pg_low: assert property (feedbackOver [*4] |-> !powerGoodOut)
      else $error("power good high under overvoltage");
   a_hot_stops: assert property (overTemp [*4] |-> !converterRun)
      else $error("converter runs while hot");
   a_in_flag: assert property (inputSenseHigh [*4] |-> inputOvervoltageFlagOe)
      else $error("input flag not pulled");
   a_out_latch: assert property (outputSenseHigh [*4] |->
      outputOvervoltageFlagOe && !converterRun)
      else $error("output overvoltage not latched");
   a_latch_holds: assert property ((!psel && !overTemp) [*6] ##0
      !converterRun |=> !converterRun)
      else $error("converter restarted without a write");
   a_soft_no_trip: assert property ((channelPeakLimit && !outputSenseHigh &&
      !overTemp && !psel) [*4] |=> converterRun)
      else $error("soft-start stopped by overcurrent");
   c_soft_end: cover property (channelPeakLimit ##1 !channelPeakLimit);
   c_stop: cover property ($fell(converterRun));
   c_good: cover property ($rose(powerGoodOut));
endmodule : bfs_checker

bind bfs_supervisor bfs_checker chk_u (.clk(clk), .rst_n(rst_n),
   .inputSenseHigh(inputSenseHigh), .outputSenseHigh(outputSenseHigh),
   .feedbackUnder(feedbackUnder), .feedbackOver(feedbackOver),
   .overTemp(overTemp), .psel(psel), .powerGoodOut(powerGoodOut),
   .powerGoodOe(powerGoodOe), .converterRun(converterRun),
   .inputOvervoltageFlagOe(inputOvervoltageFlagOe),
   .outputOvervoltageFlagOe(outputOvervoltageFlagOe),
   .channelPeakLimit(channelPeakLimit));

// File: verification/bfs_monitor.sv
`timescale 1ns/1ps
module bfs_monitor (
   input wire logic powerGoodOe,
   input wire logic inputOvervoltageFlagOe,
   input wire logic outputOvervoltageFlagOe,
   output logic powerGoodPin,
   output logic inputOvervoltageFlagN,
   output logic outputOvervoltageFlagN
);
   // released lines go to the pull-up, never hold the last driven value
   assign powerGoodPin = !powerGoodOe;
   assign inputOvervoltageFlagN = !inputOvervoltageFlagOe;
   assign outputOvervoltageFlagN = !outputOvervoltageFlagOe;
endmodule : bfs_monitor

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int TOC = 20;
   localparam int BLK = 40;
   localparam logic [31:0] SM = 32'h0000_0F00;
   localparam logic [31:0] SOFF = 32'h0000_0100;
   localparam logic [31:0] SSOFT = 32'h0000_0200;
   localparam logic [31:0] SRUN = 32'h0000_0400;
   localparam logic [31:0] SLAT = 32'h0000_0800;
   localparam logic [11:0] ACT = bfs_pkg::OFF_CTRL;
   logic clk, rst_n, inHi, outHi, fbLo, fbHi, totHi, ssCl, hot, psel;
   logic penable, pwrite, pready, err, errSeen, pg, pgOe, inOe, outOe;
   logic run, peak, irq, pgPin, inN, outN;
   logic [3:0] chTrip;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   int failures = 0, total_checks = 0, cycles = 0;
   bfs_supervisor #(.TOTAL_OC_CYCLES(TOC), .BLANK_CYCLES(BLK)) dut_u (
      .clk(clk), .rst_n(rst_n), .inputSenseHigh(inHi),
      .outputSenseHigh(outHi), .feedbackUnder(fbLo), .feedbackOver(fbHi),
      .channelCurrentAmpTrip(chTrip), .totalCurrentMonitorHigh(totHi),
      .softStartClamped(ssCl), .overTemp(hot), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(err), .powerGoodOut(pg),
      .powerGoodOe(pgOe), .inputOvervoltageFlagOe(inOe),
      .outputOvervoltageFlagOe(outOe), .converterRun(run),
      .channelPeakLimit(peak), .irq(irq));
   bfs_monitor mon_u (.powerGoodOe(pgOe), .inputOvervoltageFlagOe(inOe),
      .outputOvervoltageFlagOe(outOe), .powerGoodPin(pgPin),
      .inputOvervoltageFlagN(inN), .outputOvervoltageFlagN(outN));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (failures == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] rd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no wait-state limit here: the cycle timeout cuts a hang
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      errSeen = err;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, a, d, x);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] m,
         input logic [31:0] e);
      logic [31:0] x;
      apb(1'b0, a, 32'h0000_0000, x);
      chk(x & m, e);
   endtask : rdc
   task automatic st(input logic [31:0] e);
      rdc(bfs_pkg::OFF_STAT, SM, e);
   endtask : st
   task automatic runup();
      ssCl <= 1'b1;
      wr(ACT, 32'h0000_0001);
      wr(ACT, 32'h0000_0003);
      cyc(5);
      st(SRUN);
      chk(pgPin, 1'b1);
   endtask : runup
   task automatic t_reset();
      chk({pgPin, irq, run, inN, outN}, 5'h03);
      st(SOFF);
      rdc(bfs_pkg::OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
      rdc(12'h010, 32'hFFFF_FFFF, 32'h0000_0000);
      chk(errSeen, 1'b1);
   endtask : t_reset
   task automatic t_soft();
      wr(ACT, 32'h0000_0001);
      chTrip <= 4'hF;
      totHi <= 1'b1;
      cyc(3 * TOC);
      chk({pgPin, peak, run}, 3'h3);
      st(SSOFT);
      chTrip <= 4'h0;
      totHi <= 1'b0;
      runup();
   endtask : t_soft
   task automatic t_fault();
      fbLo <= 1'b1;
      cyc(6);
      chk({pgPin, run}, 2'h1);
      fbLo <= 1'b0;
      fbHi <= 1'b1;
      cyc(6);
      chk({pgPin, run}, 2'h1);
      fbHi <= 1'b0;
      cyc(6);
      chk(pgPin, 1'b1);
   endtask : t_fault
   task automatic t_irq();
      wr(bfs_pkg::OFF_IRQ_MASK, 32'h0000_0001);
      inHi <= 1'b1;
      cyc(6);
      chk({inN, irq}, 2'h1);
      wr(bfs_pkg::OFF_IRQ_STAT, 32'h0000_0001);
      inHi <= 1'b0;
      cyc(6);
      chk({inN, irq}, 2'h3);
      wr(bfs_pkg::OFF_IRQ_MASK, 32'h0000_0000);
      cyc(3);
      chk(irq, 1'b0);
      wr(bfs_pkg::OFF_IRQ_STAT, 32'h0000_0001);
      rdc(bfs_pkg::OFF_IRQ_STAT, 32'h0000_0001, 32'h0000_0000);
   endtask : t_irq
   task automatic t_total();
      totHi <= 1'b1;
      cyc(TOC - 6);
      totHi <= 1'b0;
      cyc(2);
      totHi <= 1'b1;
      cyc(TOC - 6);
      totHi <= 1'b0;
      cyc(5);
      chk(run, 1'b1);
      totHi <= 1'b1;
      cyc(TOC + 6);
      chk({run, pgPin}, 2'h0);
      totHi <= 1'b0;
      cyc(20);
      st(SLAT);
      wr(ACT, 32'h0000_0000);
      st(SOFF);
   endtask : t_total
   task automatic t_chan();
      for (int i = 0; i < 4; i++) begin
         runup();
         chTrip <= 4'h1 << i;
         cyc(6);
         chk(run, 1'b0);
         chTrip <= 4'h0;
         wr(ACT, 32'h0000_0000);
      end
   endtask : t_chan
   task automatic t_blank();
      runup();
      wr(ACT, 32'h0000_0007);
      chTrip <= 4'h2;
      cyc(BLK - 12);
      chk(run, 1'b1);
      cyc(20);
      chk(run, 1'b0);
      chTrip <= 4'h0;
      wr(ACT, 32'h0000_0000);
   endtask : t_blank
   task automatic t_outhot();
      runup();
      outHi <= 1'b1;
      cyc(6);
      chk({outN, run}, 2'h0);
      outHi <= 1'b0;
      st(SLAT);
      wr(ACT, 32'h0000_0000);
      runup();
      hot <= 1'b1;
      cyc(6);
      chk({run, pgPin}, 2'h0);
      hot <= 1'b0;
      cyc(6);
      chk(run, 1'b1);
   endtask : t_outhot
   initial begin
      rst_n = 1'b0;
      {inHi, outHi, fbLo, fbHi, totHi, ssCl, hot, chTrip} = '0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_soft();
      t_fault();
      t_irq();
      t_total();
      t_chan();
      t_blank();
      t_outhot();
      end_sim();
   end
endmodule : testbench
